// *** rtl/fma_unit.sv ***
// fused multiply-add/subtract unit with an AXI4-Lite register port
`timescale 1ns/1ns
`default_nettype none
module fma_unit import fma_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) o[i*8 +: 8] = d[i*8 +: 8];
        end
        return o;
    endfunction : merge

    function automatic logic f_nan(input logic [63:0] x);
        return (&x[62:52]) && (|x[51:0]);
    endfunction : f_nan

    function automatic logic f_snan(input logic [63:0] x);
        return f_nan(x) && !x[51];
    endfunction : f_snan

    function automatic logic f_inf(input logic [63:0] x);
        return (&x[62:52]) && !(|x[51:0]);
    endfunction : f_inf

    function automatic logic f_zero(input logic [63:0] x);
        return !(|x[62:0]);
    endfunction : f_zero

    function automatic logic signed [13:0] exp_of(input logic [63:0] x);
        return (x[62:52] == 11'h000) ? DBL_EMIN : $signed({3'h0, x[62:52]});
    endfunction : exp_of

    function automatic logic [163:0] shr_st(input logic [163:0] x, input logic [13:0] n);
        logic [163:0] m;
        m = '1;
        if (n >= 14'd164) return {163'h0, |x};
        m = ~(m << n);
        return (x >> n) | {163'h0, |(x & m)};
    endfunction : shr_st

    function automatic logic [7:0] lead_one(input logic [163:0] x);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 164; i++) begin
            if (x[i]) p = i[7:0];
        end
        return p;
    endfunction : lead_one

    function automatic logic [4:0] class_of(input logic [63:0] x);
        if (f_nan(x)) return CLS_QNAN;
        if (f_inf(x)) return x[63] ? CLS_NINF : CLS_PINF;
        if (f_zero(x)) return x[63] ? CLS_NZERO : CLS_PZERO;
        if (x[62:52] == 11'h000) return x[63] ? CLS_NDEN : CLS_PDEN;
        return x[63] ? CLS_NNORM : CLS_PNORM;
    endfunction : class_of

    state_t state_q;
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, rmux;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_fire, go, finish;
    logic [2:0] ctl_q;
    logic [63:0] opa_q, opb_q, opc_q, result_q;
    logic [31:0] fp_status_control_reg_q, fsr_d, exc;
    logic [3:0] condition_flags_reg_q;
    logic osub_q, osgl_q, orec_q;
    logic [1:0] rm_q;

    // register port
    assign awready = !aw_full_q;
    assign wready = !w_full_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign go = wr_fire && awaddr_q == OFS_CTRL && wstrb_q[0] && wdata_q[CTL_GO]
                && state_q == S_IDLE;
    assign finish = state_q == S_ROUND;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_D_HI) ? RESP_OKAY
                                                                           : RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        rmux = 32'h0;
        case (araddr)
            OFS_CTRL: rmux = {23'h0, state_q != S_IDLE, 4'h0, ctl_q, 1'b0};
            OFS_STAT: rmux = fp_status_control_reg_q;
            OFS_COND: rmux = {28'h0, condition_flags_reg_q};
            OFS_A_LO: rmux = opa_q[31:0];
            OFS_A_HI: rmux = opa_q[63:32];
            OFS_B_LO: rmux = opb_q[31:0];
            OFS_B_HI: rmux = opb_q[63:32];
            OFS_C_LO: rmux = opc_q[31:0];
            OFS_C_HI: rmux = opc_q[63:32];
            OFS_D_LO: rmux = result_q[31:0];
            OFS_D_HI: rmux = result_q[63:32];
            default: rmux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rmux;
            rresp_q <= (araddr[1:0] == 2'h0 && araddr <= OFS_D_HI) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // software-written operands and mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= 3'h0;
            opa_q <= RES_RST;
            opb_q <= RES_RST;
            opc_q <= RES_RST;
        end else if (wr_fire) begin
            case (awaddr_q)
                OFS_CTRL: ctl_q <= wstrb_q[0] ? wdata_q[CTL_REC:CTL_SUB] : ctl_q;
                OFS_A_LO: opa_q[31:0] <= merge(opa_q[31:0], wdata_q, wstrb_q);
                OFS_A_HI: opa_q[63:32] <= merge(opa_q[63:32], wdata_q, wstrb_q);
                OFS_B_LO: opb_q[31:0] <= merge(opb_q[31:0], wdata_q, wstrb_q);
                OFS_B_HI: opb_q[63:32] <= merge(opb_q[63:32], wdata_q, wstrb_q);
                OFS_C_LO: opc_q[31:0] <= merge(opc_q[31:0], wdata_q, wstrb_q);
                OFS_C_HI: opc_q[63:32] <= merge(opc_q[63:32], wdata_q, wstrb_q);
                default: ;
            endcase
        end
    end

    // sequencer: one state per datapath stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            osub_q <= 1'b0;
            osgl_q <= 1'b0;
            orec_q <= 1'b0;
            rm_q <= RM_NEAR;
        end else begin
            case (state_q)
                S_IDLE: if (go) begin
                    state_q <= S_PROD;
                    osub_q <= wdata_q[CTL_SUB];
                    osgl_q <= wdata_q[CTL_SGL];
                    orec_q <= wdata_q[CTL_REC];
                    rm_q <= fp_status_control_reg_q[ROUNDING_MODE_FIELD_LO +: 2];
                end
                S_PROD: state_q <= S_ALIGN;
                S_ALIGN: state_q <= S_NORM;
                S_NORM: state_q <= S_ROUND;
                S_ROUND: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // stage 1: exact product and special operands
    logic [105:0] prod_q;
    logic [52:0] mb_q;
    logic signed [13:0] pexp_q, bexp_q, emax_q, rexp_q;
    logic psign_q, asign_q, spec_q, snan_q, imz_q, isi_q, rsign_q, zero_q;
    logic [63:0] spec_res_q;
    logic any_nan, imz, isi, psign, asign;

    assign psign = opa_q[63] ^ opc_q[63];
    assign asign = opb_q[63] ^ osub_q;
    assign any_nan = f_nan(opa_q) || f_nan(opb_q) || f_nan(opc_q);
    assign imz = (f_inf(opa_q) && f_zero(opc_q)) || (f_zero(opa_q) && f_inf(opc_q));
    assign isi = (f_inf(opa_q) || f_inf(opc_q)) && f_inf(opb_q) && psign != asign && !any_nan;

    always_ff @(posedge aclk) begin
        if (state_q == S_PROD) begin
            prod_q <= {opa_q[62:52] != 11'h0, opa_q[51:0]}
                      * {opc_q[62:52] != 11'h0, opc_q[51:0]};
            mb_q <= {opb_q[62:52] != 11'h0, opb_q[51:0]};
            pexp_q <= (f_zero(opa_q) || f_zero(opc_q)) ? EXP_FLOOR
                      : exp_of(opa_q) + exp_of(opc_q) - EXP_BIAS;
            bexp_q <= f_zero(opb_q) ? EXP_FLOOR : exp_of(opb_q);
            psign_q <= psign;
            asign_q <= asign;
            snan_q <= f_snan(opa_q) || f_snan(opb_q) || f_snan(opc_q);
            imz_q <= imz;
            isi_q <= isi;
            spec_q <= any_nan || imz || isi || f_inf(opa_q) || f_inf(opb_q) || f_inf(opc_q);
            if (f_nan(opa_q)) spec_res_q <= opa_q | 64'h0008_0000_0000_0000;
            else if (f_nan(opb_q)) spec_res_q <= opb_q | 64'h0008_0000_0000_0000;
            else if (f_nan(opc_q)) spec_res_q <= opc_q | 64'h0008_0000_0000_0000;
            else if (imz || isi) spec_res_q <= QNAN_DEF;
            else if (f_inf(opa_q) || f_inf(opc_q)) spec_res_q <= {psign, 11'h7ff, 52'h0};
            else spec_res_q <= {asign, 11'h7ff, 52'h0};
        end
    end

    // stage 2: align the addend against the unrounded product and combine
    logic signed [14:0] diff;
    logic signed [14:0] ndiff;
    logic [163:0] pf, af, sum_d, sum_q, norm_q;
    logic rsign_d;

    assign diff = {pexp_q[13], pexp_q} - {bexp_q[13], bexp_q};
    assign ndiff = -diff;

    always_comb begin
        pf = {2'h0, prod_q, 56'h0};
        af = {3'h0, mb_q, 108'h0};
        if (diff >= 0) af = shr_st(af, diff[13:0]);
        else pf = shr_st(pf, ndiff[13:0]);
        rsign_d = psign_q;
        if (psign_q == asign_q) begin
            sum_d = pf + af;
        end else if (pf >= af) begin
            sum_d = pf - af;
        end else begin
            sum_d = af - pf;
            rsign_d = asign_q;
        end
        if (sum_d == 164'h0) rsign_d = (psign_q == asign_q) ? psign_q : (rm_q == RM_NEG);
    end

    always_ff @(posedge aclk) begin
        if (state_q == S_ALIGN) begin
            sum_q <= sum_d;
            rsign_q <= rsign_d;
            emax_q <= (diff >= 0) ? pexp_q : bexp_q;
        end
    end
    logic [7:0] lead;

    // stage 3: normalize so the leading one sits at bit 162, one below the top bit
    assign lead = lead_one(sum_q);
    always_ff @(posedge aclk) begin
        if (state_q == S_NORM) begin
            norm_q <= sum_q << (LEAD_POS - lead);
            rexp_q <= emax_q + $signed({6'h0, lead}) - NORM_OFS;
            zero_q <= sum_q == 164'h0;
        end
    end

    // stage 4: round to target precision and pack
    logic [53:0] mant;
    logic signed [13:0] e, lo, hi;
    logic g, st, lsb, inc, ox, ux, xx, fr, tmax, invalid, trap;
    logic [63:0] res_d;
    logic [51:0] frac;

    always_comb begin
        if (osgl_q) begin
            mant = {30'h0, norm_q[162:139]};
            g = norm_q[138];
            st = |norm_q[137:0];
            lsb = norm_q[139];
            lo = SGL_EMIN;
            hi = SGL_EMAX;
        end else begin
            mant = {1'b0, norm_q[162:110]};
            g = norm_q[109];
            st = |norm_q[108:0];
            lsb = norm_q[110];
            lo = DBL_EMIN;
            hi = DBL_EMAX;
        end
        case (rm_q)
            RM_NEAR: inc = g && (st || lsb);
            RM_ZERO: inc = 1'b0;
            RM_POS: inc = !rsign_q && (g || st);
            RM_NEG: inc = rsign_q && (g || st);
            default: inc = 1'b0;
        endcase
        mant = mant + {53'h0, inc};
        e = rexp_q;
        if (osgl_q ? mant[24] : mant[53]) begin
            mant = mant >> 1;
            e = e + 14'sh0001;
        end
        frac = osgl_q ? {mant[22:0], 29'h0} : mant[51:0];
        ox = 1'b0;
        ux = 1'b0;
        xx = g || st;
        tmax = rm_q == RM_ZERO || (rm_q == RM_POS && rsign_q) || (rm_q == RM_NEG && !rsign_q);
        res_d = {rsign_q, e[10:0], frac};
        if (zero_q) begin
            res_d = {rsign_q, 63'h0};
        end else if (e > hi) begin
            ox = 1'b1;
            xx = 1'b1;
            res_d = tmax ? {rsign_q, hi[10:0],
                            osgl_q ? {23'h7f_ffff, 29'h0} : 52'hf_ffff_ffff_ffff}
                         : {rsign_q, 11'h7ff, 52'h0};
        end else if (e < lo) begin
            ux = 1'b1;
            xx = 1'b1;
            res_d = {rsign_q, 63'h0};
        end
        fr = inc && !ox && !ux;
        if (spec_q) begin
            res_d = spec_res_q;
            {ox, ux, xx, fr} = 4'h0;
        end
        invalid = spec_q && (snan_q || imz_q || isi_q);
        trap = invalid && fp_status_control_reg_q[INVALID_OP_TRAP_ENABLE];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) result_q <= RES_RST;
        else if (finish && !trap) result_q <= res_d;
    end

    // status: hardware sets win over a software write in the same cycle
    always_comb begin
        fsr_d = fp_status_control_reg_q;
        if (wr_fire && awaddr_q == OFS_STAT) fsr_d = merge(fsr_d, wdata_q, wstrb_q);
        exc = 32'h0;
        if (finish) begin
            exc[ST_SNAN] = spec_q && snan_q;
            exc[ST_ISI] = spec_q && isi_q;
            exc[ST_IMZ] = spec_q && imz_q;
            exc[ST_OX] = ox;
            exc[ST_UX] = ux;
            exc[ST_XX] = xx;
            fsr_d = fsr_d | exc;
            if (|(exc & ~fp_status_control_reg_q)) fsr_d[ST_FX] = 1'b1;
            fsr_d[ST_FR] = fr;
            fsr_d[ST_FI] = xx;
            if (!trap) fsr_d[RESULT_CLASS_FLAGS_LO +: 5] = class_of(res_d);
        end
        fsr_d[ST_VX] = fsr_d[ST_SNAN] | fsr_d[ST_ISI] | fsr_d[ST_IMZ];
        fsr_d[ST_FEX] = (fsr_d[ST_VX] & fsr_d[INVALID_OP_TRAP_ENABLE])
                      | (fsr_d[ST_OX] & fsr_d[ST_OE]) | (fsr_d[ST_UX] & fsr_d[ST_UE])
                      | (fsr_d[ST_XX] & fsr_d[ST_XE]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) fp_status_control_reg_q <= STAT_RST;
        else fp_status_control_reg_q <= fsr_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) condition_flags_reg_q <= COND_RST;
        else if (finish && orec_q)
            condition_flags_reg_q <= {fsr_d[ST_FX], fsr_d[ST_FEX], fsr_d[ST_VX], fsr_d[ST_OX]};
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start;
        state_q == S_IDLE && go;
    endsequence
    sequence s_stages;
        state_q == S_PROD ##1 state_q == S_ALIGN ##1 state_q == S_NORM ##1 state_q == S_ROUND;
    endsequence

    a_fused_flow : assert property (s_start |=> s_stages ##1 state_q == S_IDLE)
        else $error("operation did not pass the four stages");
    a_full_product : assert property (state_q == S_PROD |=> prod_q
            == {$past(opa_q[62:52]) != 11'h0, $past(opa_q[51:0])}
             * {$past(opc_q[62:52]) != 11'h0, $past(opc_q[51:0])})
        else $error("product truncated");
    a_prod_sign : assert property (state_q == S_PROD |=> psign_q
            == ($past(opa_q[63]) ^ $past(opc_q[63])))
        else $error("product sign wrong");
    a_sub_sign : assert property (state_q == S_PROD |=> asign_q
            == ($past(opb_q[63]) ^ osub_q))
        else $error("addend sign not negated for subtract");
    a_norm_lead : assert property (state_q == S_ROUND && sum_q != 164'h0 |-> norm_q[162])
        else $error("result not normalized");
    a_result_write : assert property (finish && !trap |=> result_q == $past(res_d))
        else $error("result not written");
    a_single_round : assert property (finish && osgl_q && !spec_q && !ox
            |-> res_d[28:0] == 29'h0)
        else $error("single result has extra fraction bits");
    a_class_load : assert property (finish && !trap |=> fp_status_control_reg_q[16:12]
            == class_of($past(res_d)))
        else $error("class flags not loaded");
    a_class_hold : assert property (finish && trap && !(wr_fire && awaddr_q == OFS_STAT)
            |=> $stable(fp_status_control_reg_q[16:12]))
        else $error("class flags changed on trapped invalid");
    a_cond_hold : assert property (!(finish && orec_q) |=> $stable(condition_flags_reg_q))
        else $error("condition flags changed without record form");
    a_cond_copy : assert property (finish && orec_q |=> condition_flags_reg_q
            == {fp_status_control_reg_q[31:28]})
        else $error("condition flags not copied from status");
endmodule : fma_unit
`default_nettype wire

// *** shared/fma_pkg.sv ***
// constants, register map and state type of the fused multiply-add unit
package fma_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_COND = 8'h08;
    localparam logic [7:0] OFS_A_LO = 8'h0c;
    localparam logic [7:0] OFS_A_HI = 8'h10;
    localparam logic [7:0] OFS_B_LO = 8'h14;
    localparam logic [7:0] OFS_B_HI = 8'h18;
    localparam logic [7:0] OFS_C_LO = 8'h1c;
    localparam logic [7:0] OFS_C_HI = 8'h20;
    localparam logic [7:0] OFS_D_LO = 8'h24;
    localparam logic [7:0] OFS_D_HI = 8'h28;
    // control register bits
    localparam int CTL_GO = 0;
    localparam int CTL_SUB = 1;
    localparam int CTL_SGL = 2;
    localparam int CTL_REC = 3;
    localparam int CTL_BUSY = 8;
    // fp_status_control_reg bits
    localparam int ST_FX = 31;
    localparam int ST_FEX = 30;
    localparam int ST_VX = 29;
    localparam int ST_OX = 28;
    localparam int ST_UX = 27;
    localparam int ST_XX = 26;
    localparam int ST_SNAN = 24;
    localparam int ST_ISI = 23;
    localparam int ST_IMZ = 20;
    localparam int ST_FR = 18;
    localparam int ST_FI = 17;
    localparam int RESULT_CLASS_FLAGS_LO = 12;
    localparam int INVALID_OP_TRAP_ENABLE = 7;
    localparam int ST_OE = 6;
    localparam int ST_UE = 5;
    localparam int ST_XE = 3;
    localparam int ROUNDING_MODE_FIELD_LO = 0;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;
    localparam logic [3:0] COND_RST = 4'h0;
    localparam logic [63:0] RES_RST = 64'h0;
    // rounding modes
    localparam logic [1:0] RM_NEAR = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_POS = 2'h2;
    localparam logic [1:0] RM_NEG = 2'h3;
    // result class encodings
    localparam logic [4:0] CLS_QNAN = 5'h11;
    localparam logic [4:0] CLS_NINF = 5'h09;
    localparam logic [4:0] CLS_NNORM = 5'h08;
    localparam logic [4:0] CLS_NDEN = 5'h18;
    localparam logic [4:0] CLS_NZERO = 5'h12;
    localparam logic [4:0] CLS_PZERO = 5'h02;
    localparam logic [4:0] CLS_PDEN = 5'h14;
    localparam logic [4:0] CLS_PNORM = 5'h04;
    localparam logic [4:0] CLS_PINF = 5'h05;
    // number format
    localparam logic signed [13:0] EXP_BIAS = 14'sh03ff;
    localparam logic signed [13:0] EXP_FLOOR = -14'sh0fa0;
    localparam logic signed [13:0] DBL_EMIN = 14'sh0001;
    localparam logic signed [13:0] DBL_EMAX = 14'sh07fe;
    localparam logic signed [13:0] SGL_EMIN = 14'sh0381;
    localparam logic signed [13:0] SGL_EMAX = 14'sh047e;
    localparam logic signed [13:0] NORM_OFS = 14'sh00a0;
    localparam logic [7:0] LEAD_POS = 8'ha2;
    localparam logic [63:0] QNAN_DEF = 64'h7ff8_0000_0000_0000;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {S_IDLE, S_PROD, S_ALIGN, S_NORM, S_ROUND} state_t;
endpackage : fma_pkg

// *** dv/axil_master.sv ***
// axi4-lite master model of the sequencer side
`timescale 1ns/1ns
`default_nettype none
module axil_master (
    // clock
    input wire logic aclk,
    // write
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit a_ok;
        bit w_ok;
        a_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            // released lines show the inverse of the last value
            if (!a_ok && awready === 1'b1) begin
                {awvalid, awaddr} <= {1'b0, ~a};
                a_ok = 1'b1;
            end
            if (!w_ok && wready === 1'b1) begin
                {wvalid, wdata} <= {1'b0, ~d};
                w_ok = 1'b1;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge aclk); while (arready !== 1'b1);
        {araddr, arvalid} <= {~a, 1'b0};
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : axil_master
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench of the fused multiply-add unit
`timescale 1ns/1ns
`default_nettype none
module tb_top import fma_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, stat, cond;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [63:0] res;
    int err_total = 0;
    int check_count = 0;
    always #20 aclk = ~aclk;
    fma_unit dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    axil_master m (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic run_op(input logic [63:0] a, b, c, input logic [3:0] ctl);
        logic [31:0] lo;
        logic [31:0] hi;
        int n;
        n = 0;
        m.wr(OFS_A_LO, a[31:0], resp);
        m.wr(OFS_A_HI, a[63:32], resp);
        m.wr(OFS_B_LO, b[31:0], resp);
        m.wr(OFS_B_HI, b[63:32], resp);
        m.wr(OFS_C_LO, c[31:0], resp);
        m.wr(OFS_C_HI, c[63:32], resp);
        m.wr(OFS_CTRL, {28'h0, ctl}, resp);
        chk("go resp", RESP_OKAY, resp);
        do begin
            m.rd(OFS_CTRL, lo, resp);
            n++;
        end while (lo[CTL_BUSY] !== 1'b0 && n < 50);
        chk("busy", 64'h0, lo[CTL_BUSY]);
        m.rd(OFS_D_LO, lo, resp);
        m.rd(OFS_D_HI, hi, resp);
        res = {hi, lo};
        m.rd(OFS_STAT, stat, resp);
        m.rd(OFS_COND, cond, resp);
    endtask : run_op
    task automatic t_reset;
        m.rd(OFS_STAT, stat, resp);
        chk("status", STAT_RST, stat);
        m.rd(OFS_COND, cond, resp);
        chk("cond", COND_RST, cond);
        m.rd(8'h2c, cond, resp);
        chk("unmapped resp", RESP_SLVERR, resp);
        m.wr(8'h2c, 32'h0, resp);
        chk("unmapped wr resp", RESP_SLVERR, resp);
        $display("test reset done");
    endtask : t_reset
    task automatic t_add_sub;
        run_op(64'h4000000000000000, 64'h3ff0000000000000, 64'h4008000000000000, 4'h1);
        chk("add result", 64'h401c000000000000, res);
        chk("add class", CLS_PNORM, stat[16:12]);
        chk("cond kept", COND_RST, cond);
        run_op(64'h4000000000000000, 64'h3ff0000000000000, 64'h4008000000000000, 4'h3);
        chk("sub result", 64'h4014000000000000, res);
        $display("test add and subtract done");
    endtask : t_add_sub
    task automatic t_fused;
        // product 1+2^-29+2^-60 less 1+2^-29 leaves 2^-60 only if unrounded
        run_op(64'h3ff0000000400000, 64'h3ff0000000800000, 64'h3ff0000000400000, 4'h3);
        chk("fused result", 64'h3c30000000000000, res);
        $display("test fused done");
    endtask : t_fused
    task automatic t_single;
        m.wr(OFS_STAT, {30'h0, RM_POS}, resp);
        run_op(64'h3ff0000000400000, 64'h0, 64'h3ff0000000000000, 4'hd);
        chk("single up", 64'h3ff0000020000000, res);
        chk("record cond", 64'h8, cond);
        m.wr(OFS_STAT, {30'h0, RM_NEG}, resp);
        run_op(64'hbff0000000400000, 64'h0, 64'h3ff0000000000000, 4'h5);
        chk("single down", 64'hbff0000020000000, res);
        chk("neg class", CLS_NNORM, stat[16:12]);
        m.wr(OFS_STAT, {30'h0, RM_ZERO}, resp);
        run_op(64'hbff0000000400000, 64'h0, 64'h3ff0000000000000, 4'h5);
        chk("single trunc", 64'hbff0000000000000, res);
        m.wr(OFS_STAT, 32'h0, resp);
        run_op(64'h3ff0000000400000, 64'h0, 64'h3ff0000000000000, 4'h5);
        chk("single near", 64'h3ff0000000000000, res);
        $display("test single done");
    endtask : t_single
    task automatic t_invalid;
        m.wr(OFS_STAT, 32'h0000_4080, resp);
        run_op(64'h7ff0000000000000, 64'h3ff0000000000000, 64'h0, 4'h1);
        chk("trapped class", CLS_PNORM, stat[16:12]);
        chk("inf times zero", 64'h1, stat[ST_IMZ]);
        chk("trapped result", 64'h3ff0000000000000, res);
        m.wr(OFS_STAT, 32'h0, resp);
        run_op(64'h7ff0000000000000, 64'h3ff0000000000000, 64'h0, 4'h1);
        chk("nan result", QNAN_DEF, res);
        chk("nan class", CLS_QNAN, stat[16:12]);
        chk("cond unchanged", 64'h8, cond);
        $display("test invalid done");
    endtask : t_invalid
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_add_sub();
        t_fused();
        t_single();
        t_invalid();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
